// >>> pkg/wiper_consts.svh
/*
  Constants for the up/down wiper counter: width, tap count, midscale.
  Assumes inclusion by bare name from the design files.
*/
`ifndef WIPER_CONSTS_SVH
`define WIPER_CONSTS_SVH
// Six-bit tap code
`define WIPER_WIDTH 6
// Number of taps on the resistor ladder
`define WIPER_TAPS 64
// Power-on preset, midscale
`define WIPER_MIDSCALE 6'h20
// Ends of the range
`define WIPER_MAX 6'h3f
`define WIPER_MIN 6'h00
// Synchroniser depth for pin inputs
`define SYNC_STAGES 3
`endif

// >>> pkg/wiper_pkg.sv
/*
  Types shared by the wiper counter design.
  Assumes the constants header is compiled alongside.
*/
package wiper_pkg;
  // Step direction, taken from the direction pin
  typedef enum logic [0:0] {
    dir_down_t_e = 1'b0,
    dir_up_t_e = 1'b1
  } step_dir_t;
endpackage : wiper_pkg

// >>> hdl/pin_sync.sv
/*
  Three-stage synchroniser for one pin, with a settled output that
  changes only once the second and third stages agree.
  Assumes clk_sys and an asynchronous active-low reset.
*/
`timescale 1ns/100ps
module pin_sync #(
  parameter logic RESET_LEVEL = 1'b1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Pin in, settled level out
  input wire logic pin,
  output logic level
);
  // Stage registers; stage 0 is read only by stage 1
  logic [2:0] stage;

  // ----------------------------------------
  // Shift chain
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      stage <= {3{RESET_LEVEL}};
    end else begin
      stage <= {stage[1:0], pin};
    end
  end

  // ----------------------------------------
  // Settled level: update only on agreement
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      level <= RESET_LEVEL;
    end else if (stage[1] == stage[2]) begin
      level <= stage[2];
    end
  end
endmodule : pin_sync

// >>> hdl/updown_wiper_counter.sv
/*
  Up/down wiper position counter for a 64-tap resistor ladder, driven by
  select_n, step clock and direction pins, sampled on clk_sys.
  Assumes the pins are asynchronous to clk_sys, the step clock is
  debounced outside, and rstn stands for power-on reset.
*/
`timescale 1ns/100ps
`include "wiper_consts.svh"

// How it works
// - Hold one of 64 positions, six bits
// - Power-on loads midscale before any step
// - Only step clock falling edges act
// - Select low: each edge moves one position
// - Direction sampled at the step edge
// - Direction high up, low down
// - Select high: edges ignored, position kept
// - Constant direction keeps stepping until end
// - Saturate at ends, never wrap around
// - A-side code is complement of B-side
module updown_wiper_counter
  import wiper_pkg::*;
#(
  parameter int WIDTH = `WIPER_WIDTH
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Control pins from the host
  input wire logic select_n,
  input wire logic step_clk,
  input wire logic dir_up,
  // Tap codes to the resistor ladder
  output logic [WIDTH-1:0] wiper_b_code,
  output logic [WIDTH-1:0] wiper_a_code
);
  // Settled pin levels
  logic select_n_s;
  logic step_clk_s;
  logic dir_up_s;
  // Previous step level, for edge detection
  logic step_prev;
  // One-cycle step event
  logic step_fall;
  // Direction of the current step
  step_dir_t dir;
  // Position and its next value
  logic [WIDTH-1:0] position;
  logic [WIDTH-1:0] next_position;
  // Length of the current same-direction run, for coverage only
  logic [2:0] run_len;
  // Direction of the last accepted step
  logic run_up;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Raw pins and settled levels: [0] select, [1] step clock, [2] direction
  logic [2:0] pin_raw;
  logic [2:0] pin_settled;
  // Packed so that one loop builds every synchroniser
  assign pin_raw = {dir_up, step_clk, select_n};
  // All pins reset high; a high step clock cannot fake an edge
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      pin_sync #(
        .RESET_LEVEL(1'b1)
      ) u_sync (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .pin(pin_raw[g]),
        .level(pin_settled[g])
      );
    end
  endgenerate
  // Settled levels by name
  assign select_n_s = pin_settled[0];
  assign step_clk_s = pin_settled[1];
  assign dir_up_s = pin_settled[2];

  // ----------------------------------------
  // Falling edge detect on settled step clock
  // ----------------------------------------
  // Reset high like the settled step clock; a low pin at power-on still gives one edge once it settles
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      step_prev <= 1'b1;
    end else begin
      step_prev <= step_clk_s;
    end
  end
  assign step_fall = step_prev & ~step_clk_s;

  // Accepted step: settled falling edge while selected
  function automatic logic step_taken(input logic fall, input logic sel_n);
    return fall & ~sel_n;
  endfunction : step_taken

  // Direction is the settled level in the edge cycle
  assign dir = step_dir_t'(dir_up_s);

  // ----------------------------------------
  // Next position with saturation
  // ----------------------------------------
  always_comb begin
    next_position = position;
    // Deselected edges fall through and keep the position
    if (step_taken(step_fall, select_n_s)) begin
      // One position per edge, held at either end
      case (dir)
        dir_up_t_e: begin
          if (position != `WIPER_MAX) begin
            next_position = position + 6'h01;
          end
        end
        dir_down_t_e: begin
          if (position != `WIPER_MIN) begin
            next_position = position - 6'h01;
          end
        end
        default: begin
          next_position = position;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Position register, midscale at power-on
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      position <= `WIPER_MIDSCALE;
    end else begin
      position <= next_position;
    end
  end

  // ----------------------------------------
  // Same-direction run length
  // ----------------------------------------
  // Feeds a cover only; saturates so a long climb cannot wrap it
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      run_len <= 3'h0;
      run_up <= 1'b1;
    end else if (step_taken(step_fall, select_n_s)) begin
      run_up <= dir_up_s;
      if (run_up != dir_up_s) begin
        // A new direction restarts the run
        run_len <= 3'h1;
      end else if (run_len != 3'h7) begin
        // Same direction lengthens it
        run_len <= run_len + 3'h1;
      end
    end
  end

  // ----------------------------------------
  // Ladder codes, registered
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wiper_b_code <= `WIPER_MIDSCALE;
      wiper_a_code <= ~`WIPER_MIDSCALE;
    end else begin
      wiper_b_code <= next_position;
      wiper_a_code <= ~next_position;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // Accepted up step adds exactly one below the top
  a_step_up_one: assert property (@(posedge clk_sys) disable iff (!rstn)
    step_fall && !select_n_s && dir_up_s && position != `WIPER_MAX
    |=> position == $past(position) + 6'h01)
    else $error("up step did not add one");
  // Accepted down step takes exactly one above the bottom
  a_step_down_one: assert property (@(posedge clk_sys) disable iff (!rstn)
    step_fall && !select_n_s && !dir_up_s && position != `WIPER_MIN
    |=> position == $past(position) - 6'h01)
    else $error("down step did not subtract one");
  // Deselected: no edge may move the position
  a_select_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
    select_n_s |=> $stable(position))
    else $error("position moved while deselected");
  // Rising edges and steady levels leave it alone
  a_no_edge_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
    !step_fall |=> $stable(position))
    else $error("position moved without falling edge");
  // Top end holds against further up steps
  a_sat_top: assert property (@(posedge clk_sys) disable iff (!rstn)
    position == `WIPER_MAX && dir_up_s |=> position == `WIPER_MAX)
    else $error("wrapped past top");
  // Bottom end holds against further down steps
  a_sat_bottom: assert property (@(posedge clk_sys) disable iff (!rstn)
    position == `WIPER_MIN && !dir_up_s |=> position == `WIPER_MIN)
    else $error("wrapped past bottom");
  // Both ladder codes follow the position, the A side mirrored
  a_a_side_comp: assert property (@(posedge clk_sys) disable iff (!rstn)
    wiper_a_code == ~wiper_b_code && wiper_b_code == position)
    else $error("ladder codes not complementary");
  // Reset leaves midscale in place for the first edge
  a_reset_mid: assert property (@(posedge clk_sys)
    !rstn |=> position == `WIPER_MIDSCALE || !rstn)
    else $error("no midscale after reset");
  // Between the ends, every move follows the sampled level
  a_dir_held: assert property (@(posedge clk_sys) disable iff (!rstn)
    step_taken(step_fall, select_n_s) && position != `WIPER_MAX
    && position != `WIPER_MIN
    |=> (position == $past(position) + 6'h01) == $past(dir_up_s))
    else $error("direction run broken");
  // Any change of position is a single step
  a_range_ok: assert property (@(posedge clk_sys) disable iff (!rstn)
    $changed(position) |-> position - $past(position) == 6'h01
    || $past(position) - position == 6'h01)
    else $error("position jumped more than one");

  c_step_up: cover property (@(posedge clk_sys) disable iff (!rstn)
    step_fall && !select_n_s && dir_up_s);
  c_step_down: cover property (@(posedge clk_sys) disable iff (!rstn)
    step_fall && !select_n_s && !dir_up_s);
  c_at_top: cover property (@(posedge clk_sys) disable iff (!rstn)
    position == `WIPER_MAX);
  c_deselected_edge: cover property (@(posedge clk_sys)
    disable iff (!rstn) step_fall && select_n_s);
  // A long run of steps in one direction
  c_long_run: cover property (@(posedge clk_sys) disable iff (!rstn)
    run_len == 3'h7);
endmodule : updown_wiper_counter

// >>> dv/host_model.sv
/*
  Host model that drives the counter pins like a debounced controller.
  Assumes clk_sys from the bench; pins move on its falling edge.
*/
`timescale 1ns/100ps
module host_model (
  // Clock
  input wire logic clk_sys,
  // Pins to the counter
  output logic select_n,
  output logic step_clk,
  output logic dir_up
);
  // -----------------------------
  // Idle levels and press phases
  // -----------------------------
  // Idle: deselected, clock high
  initial begin
    select_n = 1'b1;
    step_clk = 1'b1;
    dir_up = 1'b1;
  end
  // Levels settle well before the edge, then one clean fall
  task automatic fall(input logic sel_n, input logic up);
    @(negedge clk_sys);
    select_n = sel_n;
    dir_up = up;
    repeat (5) @(negedge clk_sys);
    step_clk = 1'b0;
    repeat (7) @(negedge clk_sys);
  endtask : fall
  // Release the press; held long so no bounce is seen
  task automatic rise();
    step_clk = 1'b1;
    repeat (7) @(negedge clk_sys);
  endtask : rise
endmodule : host_model

// >>> dv/tb.sv
/*
  Self-checking bench for the wiper counter.
  Assumes the host model drives all pins.
*/
`timescale 1ns/100ps
module tb;
  // Clock, reset and pins
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic select_n;
  logic step_clk;
  logic dir_up;
  logic [5:0] wiper_b_code;
  logic [5:0] wiper_a_code;
  int n_errors = 0;
  int samples_checked = 0;
  // 200 MHz
  always #2.5 clk_sys = ~clk_sys;
  host_model host_model_inst (.clk_sys(clk_sys), .select_n(select_n),
    .step_clk(step_clk), .dir_up(dir_up));
  updown_wiper_counter updown_wiper_counter_inst (.clk_sys(clk_sys),
    .rstn(rstn), .select_n(select_n), .step_clk(step_clk),
    .dir_up(dir_up), .wiper_b_code(wiper_b_code),
    .wiper_a_code(wiper_a_code));
  // -----------------------------
  // Shared tasks
  // -----------------------------
  // Both codes at once; the A side must mirror the B side
  task automatic check(input logic [5:0] e);
    samples_checked++;
    if (wiper_b_code !== e || wiper_a_code !== ~e) begin
      n_errors++;
      $display("[FAIL] t=%0t got %h/%h exp %h", $time, wiper_b_code,
        wiper_a_code, e);
    end
  endtask : check
  // Check after the fall and again after the rise
  task automatic step(input logic s, input logic u, input logic [5:0] e);
    host_model_inst.fall(s, u);
    check(e);
    host_model_inst.rise();
    check(e);
  endtask : step
  // Power-on style reset; pins are left at their current levels
  task automatic do_reset();
    @(negedge clk_sys);
    rstn = 1'b0;
    repeat (8) @(negedge clk_sys);
    check(6'h20);
    rstn = 1'b1;
    repeat (5) @(negedge clk_sys);
    check(6'h20);
  endtask : do_reset
  task automatic test_done();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done
  // -----------------------------
  // Scenarios
  // -----------------------------
  // Deselected edges in both directions are ignored
  task automatic s_deselect();
    step(1'b1, 1'b1, 6'h20);
    step(1'b1, 1'b0, 6'h20);
  endtask : s_deselect
  // Climb to the top, then push past it
  task automatic s_top();
    for (int i = 33; i < 64; i++) begin
      step(1'b0, 1'b1, 6'(i));
    end
    step(1'b0, 1'b1, 6'h3f);
    step(1'b0, 1'b1, 6'h3f);
  endtask : s_top
  // Fall to the bottom, then push past it
  task automatic s_bottom();
    for (int i = 62; i >= 0; i--) begin
      step(1'b0, 1'b0, 6'(i));
    end
    step(1'b0, 1'b0, 6'h00);
  endtask : s_bottom
  // Direction goes up, down, up, up over four edges, from a known start position
  task automatic s_flip(input logic [5:0] base);
    step(1'b0, 1'b1, base + 6'h01);
    step(1'b0, 1'b0, base);
    step(1'b0, 1'b1, base + 6'h01);
    step(1'b0, 1'b1, base + 6'h02);
  endtask : s_flip
  // Main sequence; a second reset mid-run restores midscale
  initial begin
    repeat (8) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (5) @(negedge clk_sys);
    check(6'h20);
    s_deselect();
    s_top();
    s_bottom();
    s_flip(6'h00);
    do_reset();
    s_flip(6'h20);
    test_done();
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    test_done();
  end
endmodule : tb
